//--- src/tw_master.v
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.vh"
module tw_master (
    // APB slave
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // Interrupt
    output wire          irq,
    // Serial clock pin
    input  wire          scl_i,
    output wire          scl_o,
    output wire          scl_oe_n,
    // Serial data pin
    input  wire          sda_i,
    output wire          sda_o,
    output wire          sda_oe_n
);

    localparam ST_IDLE  = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_BYTE  = 3'd2;
    localparam ST_STOP  = 3'd3;
    localparam ST_WAIT  = 3'd4;

    // Registers seen by software
    reg        done;
    reg        ack_en;
    reg        start_req;
    reg        stop_req;
    reg        wcol;
    reg        en;
    reg [1:0]  presc;
    reg [7:0]  data_reg;
    reg [7:0]  rate;
    reg [3:0]  irq_stat;
    reg [3:0]  irq_en;
    // Engine state
    reg [2:0]  state;
    reg [1:0]  phase;
    reg [3:0]  bit_cnt;
    reg [7:0]  shift;
    reg [7:0]  code;
    reg [1:0]  mode;
    reg        addr_next;
    reg        rep_start;
    reg        ack_ok;
    reg        scl_low;
    reg        sda_low;
    reg        set_done;
    reg        arb_ev;
    reg        nack_ev;
    reg        rx_load;
    reg        stop_done;
    // Pin synchronisers
    reg [2:0]  scl_sy;
    reg [2:0]  sda_sy;
    reg        scl_s;
    reg        sda_s;

    wire       tick;
    wire       wr_acc;
    wire       hit;
    wire       ctrl_wr;
    wire       data_wr;
    wire       tx_byte;
    wire       launch;
    wire [7:0] status_code;

    // Code built from the ack bit of the byte just finished
    function [7:0] end_code;
        input       is_addr;
        input [1:0] md;
        input       ack;
        begin
            if (is_addr && md == `TW_MODE_MT)
                end_code = ack ? `TW_ST_AW_ACK : `TW_ST_AW_NACK;
            else if (is_addr)
                end_code = ack ? `TW_ST_AR_ACK : `TW_ST_AR_NACK;
            else if (md == `TW_MODE_MT)
                end_code = ack ? `TW_ST_DW_ACK : `TW_ST_DW_NACK;
            else
                end_code = ack ? `TW_ST_DR_ACK : `TW_ST_DR_NACK;
        end
    endfunction

    // Zero-wait-state bus, error on unmapped offsets
    assign hit = (paddr == `TW_OFF_CTRL) || (paddr == `TW_OFF_STATUS) ||
                 (paddr == `TW_OFF_DATA) || (paddr == `TW_OFF_RATE) ||
                 (paddr == `TW_OFF_IRQ_STAT) ||
                 (paddr == `TW_OFF_IRQ_CLR) ||
                 (paddr == `TW_OFF_IRQ_EN) || (paddr == `TW_OFF_MODE);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_acc  = psel & penable & pwrite;
    assign ctrl_wr = wr_acc && paddr == `TW_OFF_CTRL;
    assign data_wr = wr_acc && paddr == `TW_OFF_DATA;

    // Idle code whenever no event is flagged; prescaler bits masked off
    assign status_code = (done ? code : `TW_ST_IDLE) & `TW_CODE_MASK;

    // Open-drain pins: enable low only while pulling low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = ~scl_low;
    assign sda_oe_n = ~sda_low;
    assign irq      = |(irq_stat & irq_en);

    // Transmitting bytes: address always, data only in master transmit
    assign tx_byte = addr_next || mode == `TW_MODE_MT;
    assign launch  = en && !done && !set_done;

    tw_tick_gen #(
        .CW      (16)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (en),
        .rate    (rate),
        .presc   (presc),
        .tick    (tick)
    );

    // Three-stage sync; level accepted once last two stages agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
            scl_s  <= 1'b1;
            sda_s  <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[1:0], scl_i};
            sda_sy <= {sda_sy[1:0], sda_i};
            if (scl_sy[1] == scl_sy[2])
                scl_s <= scl_sy[2];
            if (sda_sy[1] == sda_sy[2])
                sda_s <= sda_sy[2];
        end
    end

    // Control register and done flag; hardware set beats software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done      <= 1'b0;
            ack_en    <= 1'b0;
            start_req <= 1'b0;
            stop_req  <= 1'b0;
            wcol      <= 1'b0;
            en        <= 1'b0;
        end else begin
            if (set_done)
                done <= 1'b1;
            else if (ctrl_wr && pwdata[`TW_CTRL_DONE])
                done <= 1'b0;
            if (ctrl_wr) begin
                ack_en    <= pwdata[`TW_CTRL_ACK_EN];
                start_req <= pwdata[`TW_CTRL_START];
                stop_req  <= pwdata[`TW_CTRL_STOP];
                en        <= pwdata[`TW_CTRL_EN];
            end else if (stop_done) begin
                stop_req  <= 1'b0;
            end
            // Data written mid-transfer is dropped and flagged
            if (data_wr && !done)
                wcol <= 1'b1;
            else if (data_wr)
                wcol <= 1'b0;
        end
    end

    // Data, rate, prescaler and interrupt registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= 8'hff;
            rate     <= `TW_RATE_RST;
            presc    <= 2'h0;
            irq_stat <= 4'h0;
            irq_en   <= 4'h0;
        end else begin
            if (rx_load)
                data_reg <= shift;
            else if (data_wr && done)
                data_reg <= pwdata[7:0];
            if (wr_acc && paddr == `TW_OFF_RATE)
                rate <= pwdata[7:0];
            if (wr_acc && paddr == `TW_OFF_STATUS)
                presc <= pwdata[`TW_PRESC_LSB+1:`TW_PRESC_LSB];
            if (wr_acc && paddr == `TW_OFF_IRQ_EN)
                irq_en <= pwdata[3:0];
            // Sticky events; a new event wins over its clear
            irq_stat <= (irq_stat &
                         ~((wr_acc && paddr == `TW_OFF_IRQ_CLR) ?
                           pwdata[3:0] : 4'h0)) |
                        {nack_ev, arb_ev, data_wr && !done, set_done};
        end
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                `TW_OFF_CTRL:     prdata <= {24'h0, done, ack_en,
                                             start_req, stop_req, wcol,
                                             en, 2'b00};
                `TW_OFF_STATUS:   prdata <= {24'h0, status_code[7:3],
                                             1'b0, presc};
                `TW_OFF_DATA:     prdata <= {24'h0, data_reg};
                `TW_OFF_RATE:     prdata <= {24'h0, rate};
                `TW_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat};
                `TW_OFF_IRQ_EN:   prdata <= {28'h0, irq_en};
                `TW_OFF_MODE:     prdata <= {30'h0, mode};
                default:          prdata <= 32'h0;
            endcase
        end
    end

    // Bus engine: four quarter-bit phases per bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            phase     <= 2'd0;
            bit_cnt   <= 4'd0;
            shift     <= 8'h0;
            code      <= `TW_ST_IDLE;
            mode      <= `TW_MODE_MT;
            addr_next <= 1'b0;
            rep_start <= 1'b0;
            ack_ok    <= 1'b0;
            scl_low   <= 1'b0;
            sda_low   <= 1'b0;
            set_done  <= 1'b0;
            arb_ev    <= 1'b0;
            nack_ev   <= 1'b0;
            rx_load   <= 1'b0;
            stop_done <= 1'b0;
        end else begin
            set_done  <= 1'b0;
            arb_ev    <= 1'b0;
            nack_ev   <= 1'b0;
            rx_load   <= 1'b0;
            stop_done <= 1'b0;
            if (!en) begin
                state   <= ST_IDLE;
                phase   <= 2'd0;
                scl_low <= 1'b0;
                sda_low <= 1'b0;
            end else begin
                case (state)
                ST_IDLE: begin
                    // Start only on a free bus
                    if (launch && start_req && scl_s && sda_s) begin
                        state     <= ST_START;
                        phase     <= 2'd0;
                        rep_start <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    scl_low <= 1'b1;
                    phase   <= 2'd0;
                    if (launch) begin
                        if (stop_req) begin
                            state <= ST_STOP;
                        end else if (start_req) begin
                            state     <= ST_START;
                            rep_start <= 1'b1;
                        end else begin
                            state   <= ST_BYTE;
                            shift   <= data_reg;
                            bit_cnt <= 4'd0;
                        end
                    end
                end
                ST_START: begin
                    if (tick) begin
                        case (phase)
                        2'd0: begin
                            sda_low <= 1'b0;
                            phase   <= 2'd1;
                        end
                        2'd1: begin
                            scl_low <= 1'b0;
                            // Slave may stretch; synced level lags a release
                            if (!scl_low && scl_s)
                                phase <= 2'd2;
                        end
                        2'd2: begin
                            sda_low <= 1'b1;
                            phase   <= 2'd3;
                        end
                        default: begin
                            scl_low   <= 1'b1;
                            state     <= ST_WAIT;
                            addr_next <= 1'b1;
                            set_done  <= 1'b1;
                            code      <= rep_start ? `TW_ST_RSTART :
                                                     `TW_ST_START;
                        end
                        endcase
                    end
                end
                ST_BYTE: begin
                    if (tick) begin
                        case (phase)
                        2'd0: begin
                            // Bit value set while clock is low
                            if (bit_cnt < `TW_BITS_PER_BYTE)
                                sda_low <= tx_byte & ~shift[7];
                            else
                                sda_low <= ~tx_byte & ack_en;
                            phase <= 2'd1;
                        end
                        2'd1: begin
                            scl_low <= 1'b0;
                            // Stale synced high would sample data too early
                            if (!scl_low && scl_s)
                                phase <= 2'd2;
                        end
                        2'd2: begin
                            if (bit_cnt < `TW_BITS_PER_BYTE &&
                                tx_byte && shift[7] && !sda_s) begin
                                // Lost arbitration: let go of the bus
                                sda_low  <= 1'b0;
                                scl_low  <= 1'b0;
                                state    <= ST_IDLE;
                                code     <= `TW_ST_ARB_LOST;
                                set_done <= 1'b1;
                                arb_ev   <= 1'b1;
                            end else begin
                                if (bit_cnt < `TW_BITS_PER_BYTE)
                                    shift <= {shift[6:0], sda_s};
                                else
                                    ack_ok <= tx_byte ? ~sda_s
                                                      : ack_en;
                                phase <= 2'd3;
                            end
                        end
                        default: begin
                            scl_low <= 1'b1;
                            if (bit_cnt == `TW_BITS_PER_BYTE) begin
                                // Ninth clock done: byte complete
                                sda_low   <= 1'b0;
                                state     <= ST_WAIT;
                                set_done  <= 1'b1;
                                nack_ev   <= tx_byte & ~ack_ok;
                                rx_load   <= ~tx_byte;
                                addr_next <= 1'b0;
                                code      <= end_code(addr_next, mode,
                                                      ack_ok);
                            end else begin
                                // Direction bit picks the master mode
                                if (addr_next &&
                                    bit_cnt == `TW_BITS_PER_BYTE - 4'd1)
                                    mode <= shift[0] ? `TW_MODE_MR
                                                     : `TW_MODE_MT;
                                bit_cnt <= bit_cnt + 4'd1;
                                phase   <= 2'd0;
                            end
                        end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        case (phase)
                        2'd0: begin
                            sda_low <= 1'b1;
                            phase   <= 2'd1;
                        end
                        2'd1: begin
                            scl_low <= 1'b0;
                            if (!scl_low && scl_s)
                                phase <= 2'd2;
                        end
                        2'd2: begin
                            sda_low <= 1'b0;
                            phase   <= 2'd3;
                        end
                        default: begin
                            // No flag after STOP; pending start follows
                            state     <= ST_IDLE;
                            stop_done <= 1'b1;
                        end
                        endcase
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- src/tw_regs.vh
`ifndef TW_REGS_VH
`define TW_REGS_VH

// Register byte offsets
`define TW_OFF_CTRL     8'h00
`define TW_OFF_STATUS   8'h04
`define TW_OFF_DATA     8'h08
`define TW_OFF_RATE     8'h0c
`define TW_OFF_IRQ_STAT 8'h10
`define TW_OFF_IRQ_CLR  8'h14
`define TW_OFF_IRQ_EN   8'h18
`define TW_OFF_MODE     8'h1c

// Control register fields
`define TW_CTRL_DONE    7
`define TW_CTRL_ACK_EN  6
`define TW_CTRL_START   5
`define TW_CTRL_STOP    4
`define TW_CTRL_WCOL    3
`define TW_CTRL_EN      2

// Status register layout
`define TW_CODE_MASK    8'hf8
`define TW_PRESC_LSB    0

// Interrupt status bits
`define TW_IRQ_DONE     0
`define TW_IRQ_WCOL     1
`define TW_IRQ_ARB      2
`define TW_IRQ_NACK     3

// Status codes
`define TW_ST_START     8'h08
`define TW_ST_RSTART    8'h10
`define TW_ST_AW_ACK    8'h18
`define TW_ST_AW_NACK   8'h20
`define TW_ST_DW_ACK    8'h28
`define TW_ST_DW_NACK   8'h30
`define TW_ST_ARB_LOST  8'h38
`define TW_ST_AR_ACK    8'h40
`define TW_ST_AR_NACK   8'h48
`define TW_ST_DR_ACK    8'h50
`define TW_ST_DR_NACK   8'h58
`define TW_ST_IDLE      8'hf8

// Mode encodings
`define TW_MODE_MT      2'b00
`define TW_MODE_MR      2'b01
`define TW_MODE_ST      2'b10
`define TW_MODE_SR      2'b11

// Rate reset value and bits per byte
`define TW_RATE_RST     8'h01
`define TW_BITS_PER_BYTE 4'd8

`endif

//--- src/tw_tick_gen.v
`timescale 1ns/1ps
`default_nettype none
// Quarter-bit enable pulse: period (rate+1) * 4^presc cycles
module tw_tick_gen #(
    parameter CW = 16
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // Control
    input  wire          run,
    input  wire [7:0]    rate,
    input  wire [1:0]    presc,
    // Enable out
    output reg           tick
);

    reg  [CW-1:0] cnt;
    wire [CW-1:0] period;

    // Prescaler multiplies by powers of four
    assign period = ({{(CW-8){1'b0}}, rate} + {{(CW-1){1'b0}}, 1'b1})
                    << {presc, 1'b0};

    // Down counter; stopped counter keeps lines quiet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            cnt  <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (cnt == {CW{1'b0}}) begin
            cnt  <= period - {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b1;
        end else begin
            cnt  <= cnt - {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- testbench/tw_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// Slave receiver: shifts bytes in, answers each with one ack bit
module tw_slave_model (
    // Bus lines as seen on the wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Test control
    input  wire logic       nack,
    // Drive and capture
    output logic            sda_low,
    output logic [7:0]      rx_byte
);
    int         cnt;
    logic [7:0] sh;

    initial begin
        sda_low = 1'b0;
        rx_byte = 8'h00;
        sh = 8'h00;
        cnt = 0;
    end

    // Start or stop on the wire restarts the bit count
    always @(sda) begin
        if (scl === 1'b1) begin
            cnt = 0;
        end
    end

    // Eight data bits, MSB first, taken while the clock is high
    always @(posedge scl) begin
        if (cnt < 8) begin
            sh = {sh[6:0], sda};
        end
        cnt = cnt + 1;
    end

    // Ack bit is ours; the line is let go once it ends
    always @(negedge scl) begin
        if (cnt == 8) begin
            rx_byte = sh;
            sda_low = !nack;
        end else if (cnt == 9) begin
            sda_low = 1'b0;
            cnt = 0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tw_master_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tw_master_checker (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        irq,
    // Serial pins
    input  wire logic        scl_i,
    input  wire logic        scl_o,
    input  wire logic        scl_oe_n,
    input  wire logic        sda_i,
    input  wire logic        sda_o,
    input  wire logic        sda_oe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase of a bus transfer
    wire acc = psel && penable;

    a_ready_always: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && paddr > 8'h1c |-> pslverr)
        else $error("no slave error on unmapped address");
    a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 0)
        else $error("upper read bits not zero");
    a_status_code: assert property (
        acc && !pwrite && paddr == 8'h04 |-> prdata[7:3] == 5'h1f
        || (prdata[7:3] != 0 && prdata[7:3] <= 5'h0b))
        else $error("status code outside legal set");
    a_scl_held: assert property (
        acc && !pwrite && paddr == 8'h00 && prdata[7] |-> !scl_oe_n [*3])
        else $error("clock line released while flag set");
    a_irq_mask: assert property (
        acc && pwrite && paddr == 8'h18 && pwdata[3:0] == 0 |=> !irq)
        else $error("interrupt high with all sources masked");
    a_start_free: assert property (
        $fell(sda_oe_n) && scl_oe_n |-> scl_i && $past(sda_i))
        else $error("start generated on busy bus");
    a_stop_idle: assert property (
        $rose(sda_oe_n) && scl_oe_n |=> (scl_oe_n && sda_oe_n) [*4])
        else $error("bus not idle after stop");

    c_start: cover property ($fell(sda_oe_n) && scl_oe_n);
    c_err: cover property (acc && pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind tw_master tw_master_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .scl_i,
    .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n);
`default_nettype wire

//--- testbench/two_wire_master_transmit_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.vh"
module two_wire_master_transmit_ctrl_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        nack = 1'b0;
    logic [31:0] prdata, rv;
    logic        pready, pslverr, irq, err;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, sda_low;
    logic [7:0]  rx_byte;
    int          n_mismatch = 0;
    int          checks = 0;
    // Pull-ups on both lines; master or slave may pull sda low, only the master pulls scl
    wire scl = scl_oe_n ? 1'b1 : scl_o;
    wire sda = (sda_oe_n ? 1'b1 : sda_o) & !sda_low;

    always #25 pclk = ~pclk;

    tw_master u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .scl_i(scl), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n));
    tw_slave_model u_slv (.scl(scl), .sda(sda), .nack(nack),
        .sda_low(sda_low), .rx_byte(rx_byte));

    task end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One transfer; released once pready is seen high or after 50 cycles
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) begin
            chk(0, 1);
            end_sim;
        end
    endtask

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Poll one control bit, bounded
    task wait_bit(input int b, input logic v);
        for (int i = 0; i < 400; i++) begin
            rd(`TW_OFF_CTRL);
            if (rv[b] === v)
                return;
        end
        chk(0, 1);
        end_sim;
    endtask

    task t_regs;
        logic [7:0] ea [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18,
                               8'h1c};
        logic [7:0] ev [7] = '{8'h00, 8'hf8, 8'hff, 8'h01, 8'h00, 8'h00,
                               8'h00};
        chk({irq, scl, sda}, 3'b011);
        for (int i = 0; i < 7; i++) begin
            rd(ea[i]);
            chk(rv, {24'h0, ev[i]});
        end
        wr(`TW_OFF_STATUS, 32'h1);
        rd(`TW_OFF_STATUS);
        chk(rv, 32'hf9);
        wr(`TW_OFF_STATUS, 32'h0);
        rd(8'h40);
        chk({31'h0, err}, 32'h1);
        chk(rv, 32'h0);
        wr(8'h40, 32'h5);
        chk(err, 1'b1);
    endtask

    // Data write with no pending flag is dropped and raises collision
    task t_wcol;
        wr(`TW_OFF_IRQ_EN, 32'h2);
        wr(`TW_OFF_DATA, 32'h77);
        rd(`TW_OFF_IRQ_STAT);
        chk({rv[1], irq}, 2'b11);
        rd(`TW_OFF_DATA);
        chk(rv, 32'hff);
        wr(`TW_OFF_IRQ_CLR, 32'h2);
        chk(irq, 1'b0);
        wr(`TW_OFF_IRQ_EN, 32'h0);
    endtask

    // START, address, one data byte, STOP; flag answered from status
    task t_xfer(input logic [7:0] a, input logic [7:0] d, input logic nk);
        nack <= nk;
        wr(`TW_OFF_IRQ_EN, 32'h1);
        wr(`TW_OFF_CTRL, 32'ha4);
        wait_bit(7, 1'b1);
        rd(`TW_OFF_STATUS);
        chk(rv & 32'hf8, 32'h08);
        chk(irq, 1'b1);
        wr(`TW_OFF_CTRL, 32'h04);
        repeat (40) @(posedge pclk);
        rd(`TW_OFF_CTRL);
        chk({rv[7], scl}, 2'b10);
        wr(`TW_OFF_IRQ_EN, 32'h0);
        chk(irq, 1'b0);
        wr(`TW_OFF_IRQ_CLR, 32'h1);
        wr(`TW_OFF_DATA, {24'h0, a});
        wr(`TW_OFF_CTRL, 32'h84);
        wait_bit(7, 1'b1);
        rd(`TW_OFF_STATUS);
        chk(rv & 32'hf8, nk ? 32'h20 : 32'h18);
        chk(rx_byte, a);
        wr(`TW_OFF_DATA, {24'h0, d});
        wr(`TW_OFF_CTRL, 32'h84);
        wait_bit(7, 1'b1);
        rd(`TW_OFF_STATUS);
        chk(rv & 32'hf8, nk ? 32'h30 : 32'h28);
        chk(rx_byte, d);
        rd(`TW_OFF_MODE);
        chk(rv, 32'h0);
        wr(`TW_OFF_CTRL, 32'h94);
        wait_bit(4, 1'b0);
        chk({rv[7], scl, sda}, 3'b011);
        rd(`TW_OFF_STATUS);
        chk(rv, 32'hf8);
    endtask

    // Address with the read bit switches the engine to master receive
    task t_read;
        nack <= 1'b0;
        wr(`TW_OFF_CTRL, 32'ha4);
        wait_bit(7, 1'b1);
        wr(`TW_OFF_DATA, 32'h5b);
        wr(`TW_OFF_CTRL, 32'h84);
        wait_bit(7, 1'b1);
        rd(`TW_OFF_STATUS);
        chk(rv & 32'hf8, 32'h40);
        rd(`TW_OFF_MODE);
        chk(rv, 32'h1);
        chk(rx_byte, 8'h5b);
        wr(`TW_OFF_CTRL, 32'h94);
        wait_bit(4, 1'b0);
        chk({rv[7], scl, sda}, 3'b011);
    endtask

    // Main sequence; the last transfer addresses with the read bit
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_wcol;
        t_xfer(8'ha4, 8'h5a, 1'b0);
        t_xfer(8'h3c, 8'hc3, 1'b1);
        t_read;
        end_sim;
    end
endmodule
`default_nettype wire
